// [inc/fsirq_regs.svh]
// Register offsets, field positions and reset values of the four-source interrupt block.
//
// Functional notes
// - Ext A trigger sets its flag always
// - Ext A enabled flag vectors to 8
// - Ext A disabled: flag set, no vector
// - Edge field bits 4:3 picks trigger
// - Ext B trigger sets its flag always
// - Ext B enabled flag vectors to 8
// - Ext B disabled: flag set, no vector
// - Ext B triggers on falling edge only
// - Base timer overflow sets its flag
// - Base timer enabled overflow vectors
// - Base timer disabled: flag, no vector
// - Second timer overflow sets its flag
// - Second timer enabled flag vectors
// - Second timer disabled: flag, no vector
// - Nothing vectors without global enable
// - Entry clears global enable, exit sets
`ifndef FSIRQ_REGS_SVH
`define FSIRQ_REGS_SVH

// ==========================================================================
// Register byte addresses.
// ==========================================================================
// The edge register keeps its word index; its byte address is four times it.
`define FSIRQ_EDGE_INDEX     12'h0BF
`define FSIRQ_EDGE_OFFSET    12'h2FC
`define FSIRQ_FLAG_OFFSET    12'h320
`define FSIRQ_ENABLE_OFFSET  12'h324
`define FSIRQ_GLOBAL_OFFSET  12'h328
`define FSIRQ_CLEAR_OFFSET   12'h32C
`define FSIRQ_VECTOR_OFFSET  12'h330

// ==========================================================================
// Field positions and reset values.
// ==========================================================================
`define FSIRQ_EDGE_LSB       3
`define FSIRQ_EDGE_MSB       4
`define FSIRQ_EDGE_RESET     2'h2
`define FSIRQ_BIT_EXT_A      0
`define FSIRQ_BIT_EXT_B      1
`define FSIRQ_BIT_BASE_TMR   4
`define FSIRQ_BIT_SEC_TMR    6
`define FSIRQ_GIE_BIT        7
`define FSIRQ_SRC_MASK       8'h53
`define FSIRQ_VECTOR_ADDR    16'h0008

`endif

// [inc/fsirq_pkg.sv]
// Types shared by the four-source interrupt block.
package fsirq_pkg;

    // Trigger selection for the first external pin.
    typedef enum logic [1:0] {
        FSIRQ_EDGE_RESERVED = 2'h0,
        FSIRQ_EDGE_RISE     = 2'h1,
        FSIRQ_EDGE_FALL     = 2'h2,
        FSIRQ_EDGE_BOTH     = 2'h3
    } fsirq_edge_t;

    // Service state, one-hot.
    typedef enum logic [1:0] {
        FSIRQ_ST_IDLE    = 2'b01,
        FSIRQ_ST_SERVICE = 2'b10
    } fsirq_state_t;

endpackage

// [core/fsirq_sync.sv]
// Two-stage synchroniser and edge detector for one external pin.
`timescale 1ns/1ps
module fsirq_sync (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic stage_one;
    logic stage_two;
    logic last_level;

    // The first stage feeds only the second; edges come from later stages.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            stage_one  <= 1'b1;
            stage_two  <= 1'b1;
            last_level <= 1'b1;
        end else begin
            stage_one  <= pin;
            stage_two  <= stage_one;
            last_level <= stage_two;
        end
    end

    // Edge pulses last one cycle.
    assign level = stage_two;
    assign rise  = stage_two & ~last_level;
    assign fall  = ~stage_two & last_level;
endmodule

// [core/fsirq_trigger.sv]
// Edge selector of the first external pin.
`timescale 1ns/1ps
module fsirq_trigger (
    input  wire logic                 rise,
    input  wire logic                 fall,
    input  wire fsirq_pkg::fsirq_edge_t ext_a_edge_select,
    output logic                      trigger
);
    // Reserved code selects no edge at all.
    always_comb begin
        case (ext_a_edge_select)
            fsirq_pkg::FSIRQ_EDGE_RISE: trigger = rise;
            fsirq_pkg::FSIRQ_EDGE_FALL: trigger = fall;
            fsirq_pkg::FSIRQ_EDGE_BOTH: trigger = rise | fall;
            default:                    trigger = 1'b0;
        endcase
    end
endmodule

// [core/fsirq_top.sv]
// Four-source interrupt flag logic with an APB register slave.
`timescale 1ns/1ps
`include "fsirq_regs.svh"
module fsirq_top (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_irq_a,
    input  wire logic        ext_irq_b,
    input  wire logic        base_timer_overflow,
    input  wire logic        second_timer_overflow,
    input  wire logic        service_exit,
    output logic             vector_req,
    output logic [15:0]      vector_addr,
    output logic             irq,
    output logic             in_service
);
    // ======================================================================
    // Pin synchronisers and edge selection.
    // ======================================================================
    logic a_rise;
    logic a_fall;
    logic b_fall;
    logic a_trig;
    fsirq_pkg::fsirq_edge_t ext_a_edge_select;

    fsirq_sync u_sync_a (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin     (ext_irq_a),
        .level   (),
        .rise    (a_rise),
        .fall    (a_fall)
    );

    fsirq_sync u_sync_b (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin     (ext_irq_b),
        .level   (),
        .rise    (),
        .fall    (b_fall)
    );

    fsirq_trigger u_trig_a (
        .rise              (a_rise),
        .fall              (a_fall),
        .ext_a_edge_select (ext_a_edge_select),
        .trigger           (a_trig)
    );

    // ======================================================================
    // Event vector in flag layout.
    // ======================================================================
    logic [7:0] events;

    // Each source maps onto its own flag bit.
    assign events = {1'b0,
                     second_timer_overflow,
                     1'b0,
                     base_timer_overflow,
                     2'b00,
                     b_fall,
                     a_trig};

    // ======================================================================
    // APB decode.
    // ======================================================================
    logic apb_access;
    logic wr;
    logic rd;
    logic hit_edge;
    logic hit_flag;
    logic hit_enable;
    logic hit_global;
    logic hit_clear;
    logic hit_vector;
    logic hit_any;

    // Zero wait states: every access completes in its first access cycle.
    assign apb_access = psel & penable;
    assign wr         = apb_access & pwrite;
    assign rd         = apb_access & ~pwrite;
    assign hit_edge   = (paddr == `FSIRQ_EDGE_OFFSET);
    assign hit_flag   = (paddr == `FSIRQ_FLAG_OFFSET);
    assign hit_enable = (paddr == `FSIRQ_ENABLE_OFFSET);
    assign hit_global = (paddr == `FSIRQ_GLOBAL_OFFSET);
    assign hit_clear  = (paddr == `FSIRQ_CLEAR_OFFSET);
    assign hit_vector = (paddr == `FSIRQ_VECTOR_OFFSET);
    assign hit_any    = hit_edge | hit_flag | hit_enable | hit_global | hit_clear | hit_vector;

    // ======================================================================
    // Registers.
    // ======================================================================
    logic [7:0] irq_flag_register;
    logic [7:0] irq_enable;
    logic       global_irq_enable;
    logic [1:0] edge_field;
    logic [7:0] clear_bits;
    logic [7:0] next_flags;
    logic [7:0] pending;
    logic       take;
    fsirq_pkg::fsirq_state_t state;
    fsirq_pkg::fsirq_state_t next_state;

    assign ext_a_edge_select = fsirq_pkg::fsirq_edge_t'(edge_field);

    // Software clears by writing ones to the flag or clear register.
    assign clear_bits = (wr & (hit_flag | hit_clear)) ? (pwdata[7:0] & `FSIRQ_SRC_MASK) : 8'h00;

    // Hardware only sets; a set in the same cycle as a clear wins.
    assign next_flags = (irq_flag_register & ~clear_bits) | (events & `FSIRQ_SRC_MASK);

    // Flags ignore the enables; the enables gate the vector and the irq output.
    assign pending = irq_flag_register & irq_enable;

    // Vector only with global enable while not already in service.
    assign take = global_irq_enable & (|pending)
                  & (state == fsirq_pkg::FSIRQ_ST_IDLE);

    // Service state machine.
    always_comb begin
        next_state = state;
        case (state)
            fsirq_pkg::FSIRQ_ST_IDLE: begin
                if (take) begin
                    next_state = fsirq_pkg::FSIRQ_ST_SERVICE;
                end
            end
            fsirq_pkg::FSIRQ_ST_SERVICE: begin
                if (service_exit) begin
                    next_state = fsirq_pkg::FSIRQ_ST_IDLE;
                end
            end
            default: next_state = fsirq_pkg::FSIRQ_ST_IDLE;
        endcase
    end

    // Flag register.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_flag_register <= 8'h00;
        end else begin
            irq_flag_register <= next_flags;
        end
    end

    // Enable and edge registers.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_enable <= 8'h00;
            edge_field <= `FSIRQ_EDGE_RESET;
        end else begin
            if (wr & hit_enable) begin
                irq_enable <= pwdata[7:0] & `FSIRQ_SRC_MASK;
            end
            if (wr & hit_edge) begin
                edge_field <= pwdata[`FSIRQ_EDGE_MSB:`FSIRQ_EDGE_LSB];
            end
        end
    end

    // Global enable: entry clears it, exit sets it, software may write it.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            global_irq_enable <= 1'b0;
        end else if (take) begin
            global_irq_enable <= 1'b0;
        end else if (service_exit & (state == fsirq_pkg::FSIRQ_ST_SERVICE)) begin
            global_irq_enable <= 1'b1;
        end else if (wr & hit_global) begin
            global_irq_enable <= pwdata[`FSIRQ_GIE_BIT];
        end
    end

    // State and vector outputs.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state       <= fsirq_pkg::FSIRQ_ST_IDLE;
            vector_req  <= 1'b0;
            vector_addr <= 16'h0000;
            in_service  <= 1'b0;
        end else begin
            state       <= next_state;
            vector_req  <= take;
            vector_addr <= `FSIRQ_VECTOR_ADDR;
            in_service  <= (next_state == fsirq_pkg::FSIRQ_ST_SERVICE);
        end
    end

    // Level interrupt from the new flag values and the current enable register.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_flags & irq_enable);
        end
    end

    // ======================================================================
    // APB answer.
    // ======================================================================
    logic [31:0] read_mux;

    // Read selection; the clear register reads as zero.
    assign read_mux = hit_edge   ? {27'h0, edge_field, 3'h0} :
                      hit_flag   ? {24'h0, irq_flag_register} :
                      hit_enable ? {24'h0, irq_enable} :
                      hit_global ? {24'h0, global_irq_enable, 5'h0, state == fsirq_pkg::FSIRQ_ST_SERVICE, 1'b0} :
                      hit_vector ? {16'h0, `FSIRQ_VECTOR_ADDR} :
                      32'h0000_0000;

    // Ready is a one-cycle pulse in the first access cycle.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_any;               // Unmapped addresses answer with an error.
            prdata  <= (psel & ~penable & ~pwrite) ? read_mux : 32'h0000_0000;
        end
    end
endmodule

// [dv/fsirq_asserts.sv]
// Port-level assertions of the four-source interrupt block.
`timescale 1ns/1ps
`include "fsirq_regs.svh"
module fsirq_asserts (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        service_exit,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        vector_req,
    input wire logic [15:0] vector_addr,
    input wire logic        irq,
    input wire logic        in_service
);
    // All checks share the block clock and its reset.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // ==========================================================
    // Vector entry, service state and exit.
    // ==========================================================
    property p_addr; vector_req |-> vector_addr == `FSIRQ_VECTOR_ADDR; endproperty
    a_addr: assert property (p_addr) else $error("bad vector address.");
    property p_cause; vector_req |-> irq; endproperty
    a_cause: assert property (p_cause) else $error("vector without enabled flag.");
    property p_pulse; vector_req |=> !vector_req; endproperty
    a_pulse: assert property (p_pulse) else $error("vector request too long.");
    property p_entry; vector_req |-> ##[0:1] in_service; endproperty
    a_entry: assert property (p_entry) else $error("no service state.");
    property p_excl; vector_req |-> !$past(in_service); endproperty
    a_excl: assert property (p_excl) else $error("vector during service.");
    property p_hold; in_service && !service_exit |=> in_service; endproperty
    a_hold: assert property (p_hold) else $error("service left early.");
    property p_exit; in_service && service_exit |-> ##[1:2] !in_service; endproperty
    a_exit: assert property (p_exit) else $error("service not left.");
    property p_vrd;
        pready && !pwrite && paddr == `FSIRQ_VECTOR_OFFSET |-> prdata == 32'h0000_0008;
    endproperty
    a_vrd: assert property (p_vrd) else $error("vector register wrong.");
endmodule

bind fsirq_top fsirq_asserts chk_u (.ref_clk(ref_clk), .rstn(rstn), .pwrite(pwrite), .paddr(paddr),
    .service_exit(service_exit), .prdata(prdata), .pready(pready), .vector_req(vector_req),
    .vector_addr(vector_addr), .irq(irq), .in_service(in_service));

// [dv/fsirq_partner.sv]
// Behavioural model of the pins, timers and CPU around the block.
`timescale 1ns/1ps
module fsirq_partner (
    input  wire logic ref_clk,
    output logic      ext_irq_a = 1'b1,
    output logic      ext_irq_b = 1'b1,
    output logic      base_timer_overflow = 1'b0,
    output logic      second_timer_overflow = 1'b0,
    output logic      service_exit = 1'b0
);
    // Moves one pin to a new level just after an edge.
    task pin(input int s, input logic v);
        @(posedge ref_clk);
        if (s == 0) ext_irq_a <= v;
        else ext_irq_b <= v;
    endtask
    // Gives one timer overflow pulse of one cycle.
    task ovf(input int s);
        @(posedge ref_clk);
        if (s == 0) base_timer_overflow <= 1'b1;
        else second_timer_overflow <= 1'b1;
        @(posedge ref_clk);
        base_timer_overflow <= 1'b0;
        second_timer_overflow <= 1'b0;
    endtask
    // Returns from the service routine.
    task ret;
        @(posedge ref_clk);
        service_exit <= 1'b1;
        @(posedge ref_clk);
        service_exit <= 1'b0;
    endtask
endmodule

// [dv/tb_four_source_irq_flags.sv]
// Self-checking bench of the four-source interrupt block.
`timescale 1ns/1ps
`include "fsirq_regs.svh"
module tb_four_source_irq_flags;
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, vector_req, irq, in_service;
    logic        ext_irq_a, ext_irq_b, tmr_a, tmr_b, svc_exit;
    logic [15:0] vector_addr;
    int          errors  = 0;
    int          n_tests = 0;
    int          nvec    = 0;

    fsirq_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .base_timer_overflow(tmr_a),
        .second_timer_overflow(tmr_b), .service_exit(svc_exit), .vector_req(vector_req),
        .vector_addr(vector_addr), .irq(irq), .in_service(in_service));
    fsirq_partner fp_u (.ref_clk(ref_clk), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b),
        .base_timer_overflow(tmr_a), .second_timer_overflow(tmr_b), .service_exit(svc_exit));

    // The clock toggles every 5 ns.
    initial forever #5 ref_clk = ~ref_clk;
    // Counts vector requests seen by the CPU.
    always @(posedge ref_clk) if (vector_req === 1'b1) nvec <= nvec + 1;

    // Prints the counts and the verdict, then stops.
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Compares one value and counts it.
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %0t got %h exp %h", $time, g, e);
            errors++;
        end
    endtask
    // One APB transfer, held until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            errors++;
            conclude;
        end
    endtask
    // Register write and checked register read.
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, x);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Reset values and an unmapped address.
    task t_regs;
        logic [31:0] q;
        logic e;
        rd(`FSIRQ_EDGE_OFFSET, 32'h0000_0010);
        rd(`FSIRQ_FLAG_OFFSET, 32'h0000_0000);
        rd(`FSIRQ_ENABLE_OFFSET, 32'h0000_0000);
        rd(`FSIRQ_GLOBAL_OFFSET, 32'h0000_0000);
        rd(`FSIRQ_VECTOR_OFFSET, 32'h0000_0008);
        apb(1'b0, 12'h100, 32'h0000_0000, q, e);
        chk({31'h0, e}, 32'h0000_0001);
        $display("t_regs done");
    endtask
    // Every edge code of pin A, each with a rising and a falling edge.
    task t_pin_a;
        logic [1:0] c;
        for (int i = 1; i < 5; i++) begin
            c = 2'(i);
            fp_u.pin(0, 1'b0);
            wr(`FSIRQ_EDGE_OFFSET, {27'h0, c, 3'h0});
            cyc(6);
            wr(`FSIRQ_CLEAR_OFFSET, 32'h0000_0001);
            fp_u.pin(0, 1'b1);
            cyc(6);
            rd(`FSIRQ_FLAG_OFFSET, {31'h0, c[0]});
            wr(`FSIRQ_CLEAR_OFFSET, 32'h0000_0001);
            fp_u.pin(0, 1'b0);
            cyc(6);
            rd(`FSIRQ_FLAG_OFFSET, {31'h0, c[1]});
        end
        chk({31'h0, irq}, 32'h0000_0000);
        $display("t_pin_a done");
    endtask
    // Pin B flags on its falling edge only.
    task t_pin_b;
        fp_u.pin(1, 1'b0);
        cyc(6);
        rd(`FSIRQ_FLAG_OFFSET, 32'h0000_0002);
        wr(`FSIRQ_CLEAR_OFFSET, 32'h0000_0002);
        fp_u.pin(1, 1'b1);
        cyc(6);
        rd(`FSIRQ_FLAG_OFFSET, 32'h0000_0000);
        $display("t_pin_b done");
    endtask
    // Timer overflows flag while masked and stay set.
    task t_tmr;
        fp_u.ovf(0);
        fp_u.ovf(1);
        cyc(8);
        rd(`FSIRQ_FLAG_OFFSET, 32'h0000_0050);
        chk({31'h0, irq}, 32'h0000_0000);
        chk(32'(nvec), 32'h0000_0000);
        wr(`FSIRQ_CLEAR_OFFSET, 32'h0000_0050);
        $display("t_tmr done");
    endtask
    // Each source enters service once the global enable is set.
    task t_vec;
        int k;
        wr(`FSIRQ_EDGE_OFFSET, 32'h0000_0018);
        wr(`FSIRQ_ENABLE_OFFSET, 32'h0000_0053);
        for (int s = 0; s < 4; s++) begin
            if (s == 0) fp_u.pin(0, ~ext_irq_a);
            else if (s == 1) fp_u.pin(1, 1'b0);
            else fp_u.ovf(s - 2);
            cyc(6);
            chk({31'h0, irq}, 32'h0000_0001);
            chk(32'(nvec), 32'(s));
            wr(`FSIRQ_GLOBAL_OFFSET, 32'h0000_0080);
            for (k = 0; k < 20 && nvec == s; k++) @(posedge ref_clk);
            chk(32'(nvec), 32'(s + 1));
            if (nvec == s) conclude;
            chk({16'h0, vector_addr}, 32'h0000_0008);
            rd(`FSIRQ_GLOBAL_OFFSET, 32'h0000_0002);
            rd(`FSIRQ_FLAG_OFFSET, 32'(1) << ((s < 2) ? s : 2 * s));
            wr(`FSIRQ_CLEAR_OFFSET, 32'h0000_0053);
            fp_u.ret;
            cyc(2);
            rd(`FSIRQ_GLOBAL_OFFSET, 32'h0000_0080);
            wr(`FSIRQ_GLOBAL_OFFSET, 32'h0000_0000);
            fp_u.pin(1, 1'b1);
        end
        $display("t_vec done");
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        t_regs;
        t_pin_a;
        t_pin_b;
        t_tmr;
        t_vec;
        conclude;
    end
endmodule
